/* File: hw/alarm_pin_driver.sv */
// One alarm pin: source pick, polarity and output register
`timescale 1ns/1ps
module alarm_pin_driver (
  // Clock and reset
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic        ce,
  // Configuration and conditions
  input  wire logic [19:0] cond,
  input  wire logic [4:0]  sel,
  input  wire logic        active_high,
  // Results
  output logic             asserted,
  output logic             pin
);

  logic picked;

  // Codes past the list read as never true
  always_comb begin
    picked = 1'b0;
    if (sel != alarm_pkg::disabled_source && sel < 5'(alarm_pkg::COND_W)) begin
      picked = cond[sel];
    end
  end

  // Registered so a mux change never glitches the pin
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      asserted <= 1'b0;
      pin      <= !alarm_pkg::CFG_POL_RST;
    end else if (ce) begin
      asserted <= picked;
      pin      <= active_high ? picked : !picked;
    end
  end

  property p_polarity;
    @(posedge aclk) disable iff (!aresetn)
    ce |=> (pin == ($past(active_high) ? asserted : !asserted));
  endproperty
  a_polarity: assert property (p_polarity) else $error("pin polarity wrong");

  property p_disabled;
    @(posedge aclk) disable iff (!aresetn)
    (ce && sel == alarm_pkg::disabled_source) |=> !asserted;
  endproperty
  a_disabled: assert property (p_disabled) else $error("disabled pin went active");

  property p_follow;
    @(posedge aclk) disable iff (!aresetn)
    (ce && sel == alarm_pkg::system_fault_source) |=> (asserted == $past(cond[15]));
  endproperty
  a_follow: assert property (p_follow) else $error("pin lags its condition");

endmodule // alarm_pin_driver

/* File: hw/alarm_pkg.sv */
// Shared constants for the alarm output mapper
package alarm_pkg;

  // ************************************************************
  // Sizes
  // ************************************************************
  localparam int NUM_OUT    = 8;
  localparam int NUM_ANALOG = 3;
  localparam int NUM_FAULT  = 10;
  localparam int SEL_W      = 5;
  localparam int COND_W     = 20;
  localparam int RANGE_W    = 16;
  localparam int ADDR_W     = 8;
  localparam int PROD_W     = 24;

  // ************************************************************
  // Source selection codes
  // ************************************************************
  localparam logic [4:0] disabled_source             = 5'h00;
  localparam logic [4:0] power_fault_source          = 5'h01;
  localparam logic [4:0] converter_fault_source      = 5'h02;
  localparam logic [4:0] storage_disconnected_source = 5'h0B;
  localparam logic [4:0] system_fault_source         = 5'h0F;
  localparam logic [4:0] maintenance_source          = 5'h10;
  localparam logic [4:0] analog_ch0_overrange_source = 5'h11;

  // ************************************************************
  // Register map (byte offsets) and fields
  // ************************************************************
  localparam logic [7:0] CFG_OFS     = 8'h00;
  localparam logic [7:0] STATUS_OFS  = 8'h20;
  localparam logic [7:0] MASK_OFS    = 8'h24;
  localparam logic [7:0] LEVEL_OFS   = 8'h28;
  localparam logic [7:0] CTRL_OFS    = 8'h2C;
  localparam logic [7:0] RANGE_OFS   = 8'h30;
  localparam int         CFG_POL_BIT = 8;
  localparam int         CTRL_MAINT  = 0;
  localparam int         CTRL_OVR_EN = 1;
  localparam int         LEVEL_OVR   = 8;

  // ************************************************************
  // Reset values
  // ************************************************************
  localparam logic [4:0]  CFG_SEL_RST = 5'h00;
  localparam logic        CFG_POL_RST = 1'b1;
  localparam logic [7:0]  MASK_RST    = 8'h00;
  localparam logic [3:0]  CTRL_RST    = 4'h0;
  localparam logic [15:0] RANGE_RST   = 16'h1000;

  // ************************************************************
  // Over-range thresholds in percent
  // ************************************************************
  localparam int OVR_ENTER_PCT = 90;
  localparam int OVR_LEAVE_PCT = 80;
  localparam int PCT_SCALE     = 100;

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage

/* File: hw/overrange_tracker.sv */
// Over-range hysteresis for one analog output channel
`timescale 1ns/1ps
module overrange_tracker (
  // Clock and reset
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic        ce,
  // Reading and scale
  input  wire logic        enable,
  input  wire logic [15:0] reading,
  input  wire logic [15:0] std_range,
  // Result
  output logic             over
);

  logic [23:0] reading_pct;
  logic [23:0] enter_lvl;
  logic [23:0] leave_lvl;
  logic        enter_hit;
  logic        leave_hit;

  // Scaled compare avoids a divider; 24 bits hold 16-bit x 100
  assign reading_pct = 24'(reading) * 24'(alarm_pkg::PCT_SCALE);
  assign enter_lvl   = 24'(std_range) * 24'(alarm_pkg::OVR_ENTER_PCT);
  assign leave_lvl   = 24'(std_range) * 24'(alarm_pkg::OVR_LEAVE_PCT);
  assign enter_hit   = reading_pct >= enter_lvl;
  assign leave_hit   = reading_pct <= leave_lvl;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      over <= 1'b0;
    end else if (ce) begin
      if (!enable) begin
        over <= 1'b0;
      end else if (over) begin
        over <= !leave_hit;
      end else begin
        over <= enter_hit;
      end
    end
  end

  property p_enter;
    @(posedge aclk) disable iff (!aresetn)
    (ce && enable && !over && enter_hit) |=> over;
  endproperty
  a_enter: assert property (p_enter) else $error("over-range not entered");

  property p_leave;
    @(posedge aclk) disable iff (!aresetn)
    (ce && over && leave_hit) |=> !over;
  endproperty
  a_leave: assert property (p_leave) else $error("over-range not left");

endmodule // overrange_tracker

/* File: hw/status_alarm_output_mapper.sv */
// Alarm output mapper top: register bus, conditions and eight alarm pins
`timescale 1ns/1ps
module status_alarm_output_mapper (
  // Clock, reset, enable
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic        ce,
  // AXI4-Lite write address
  input  wire logic [7:0]  awaddr,
  input  wire logic [2:0]  awprot,
  input  wire logic        awvalid,
  output logic             awready,
  // AXI4-Lite write data
  input  wire logic [31:0] wdata,
  input  wire logic [3:0]  wstrb,
  input  wire logic        wvalid,
  output logic             wready,
  // AXI4-Lite write response
  output logic [1:0]       bresp,
  output logic             bvalid,
  input  wire logic        bready,
  // AXI4-Lite read address
  input  wire logic [7:0]  araddr,
  input  wire logic [2:0]  arprot,
  input  wire logic        arvalid,
  output logic             arready,
  // AXI4-Lite read data
  output logic [31:0]      rdata,
  output logic [1:0]       rresp,
  output logic             rvalid,
  input  wire logic        rready,
  // Instrument conditions
  input  wire logic [9:0]  fault_flags,
  input  wire logic        storage_disconnected,
  input  wire logic        background_active,
  input  wire logic        span_active,
  input  wire logic        zero_active,
  input  wire logic        system_fault,
  // Analog channel readings
  input  wire logic [15:0] reading_ch0,
  input  wire logic [15:0] reading_ch1,
  input  wire logic [15:0] reading_ch2,
  // Alarm pins and interrupt
  output logic [7:0]       alarm_pin,
  output logic             irq
);

  // ************************************************************
  // Storage
  // ************************************************************
  logic [4:0]  cfg_sel [8];
  logic [7:0]  cfg_pol;
  logic [7:0]  status;
  logic [7:0]  mask;
  logic        maint;
  logic [2:0]  ovr_en;
  logic [15:0] std_range [3];
  logic [15:0] reading [3];
  logic [2:0]  over;
  logic [7:0]  asserted;
  logic [7:0]  asserted_d;
  logic [19:0] cond;

  // ************************************************************
  // Write channel
  // ************************************************************
  logic        aw_held;
  logic        w_held;
  logic [7:0]  aw_addr_q;
  logic [31:0] w_data_q;
  logic [3:0]  w_strb_q;
  logic [31:0] wmask;
  logic        do_write;
  logic        wr_hit;
  logic [5:0]  wr_idx;

  // Protection bits carry no meaning here
  logic        prot_unused;
  assign prot_unused = ^{awprot, arprot};

  // Address and data are taken in either order, one write at a time
  assign awready  = ce & ~aw_held & ~bvalid;
  assign wready   = ce & ~w_held & ~bvalid;
  assign do_write = ce & aw_held & w_held & ~bvalid;
  assign wr_idx   = aw_addr_q[7:2];
  assign wmask    = {{8{w_strb_q[3]}}, {8{w_strb_q[2]}},
                     {8{w_strb_q[1]}}, {8{w_strb_q[0]}}};

  function automatic logic addr_ok(input logic [5:0] idx);
    addr_ok = (idx < alarm_pkg::STATUS_OFS[7:2])
            || (idx >= alarm_pkg::STATUS_OFS[7:2] && idx <= alarm_pkg::CTRL_OFS[7:2])
            || (idx >= alarm_pkg::RANGE_OFS[7:2]
                && idx < alarm_pkg::RANGE_OFS[7:2] + 6'(alarm_pkg::NUM_ANALOG));
  endfunction

  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] nw,
                                        input logic [31:0] m);
    merge = (old & ~m) | (nw & m);
  endfunction

  assign wr_hit = addr_ok(wr_idx);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held   <= 1'b0;
      w_held    <= 1'b0;
      aw_addr_q <= 8'h00;
      w_data_q  <= 32'h00000000;
      w_strb_q  <= 4'h0;
      bvalid    <= 1'b0;
      bresp     <= alarm_pkg::RESP_OKAY;
    end else if (ce) begin
      if (awvalid && awready) begin
        aw_held   <= 1'b1;
        aw_addr_q <= awaddr;
      end
      if (wvalid && wready) begin
        w_held   <= 1'b1;
        w_data_q <= wdata;
        w_strb_q <= wstrb;
      end
      if (do_write) begin
        aw_held <= 1'b0;
        w_held  <= 1'b0;
        bvalid  <= 1'b1;
        bresp   <= wr_hit ? alarm_pkg::RESP_OKAY : alarm_pkg::RESP_SLVERR;
      end else if (bvalid && bready) begin
        bvalid <= 1'b0;
      end
    end
  end

  // ************************************************************
  // Control registers
  // ************************************************************
  logic [31:0] ctrl_new;
  logic [31:0] mask_new;
  assign ctrl_new = merge({28'h0000000, ovr_en, maint}, w_data_q, wmask);
  assign mask_new = merge({24'h000000, mask}, w_data_q, wmask);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      maint  <= alarm_pkg::CTRL_RST[alarm_pkg::CTRL_MAINT];
      ovr_en <= alarm_pkg::CTRL_RST[alarm_pkg::CTRL_OVR_EN +: 3];
    end else if (ce && do_write && wr_idx == alarm_pkg::CTRL_OFS[7:2]) begin
      maint  <= ctrl_new[alarm_pkg::CTRL_MAINT];
      ovr_en <= ctrl_new[alarm_pkg::CTRL_OVR_EN +: 3];
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      mask <= alarm_pkg::MASK_RST;
    end else if (ce && do_write && wr_idx == alarm_pkg::MASK_OFS[7:2]) begin
      mask <= mask_new[7:0];
    end
  end

  // ************************************************************
  // Condition vector
  // ************************************************************
  assign reading[0] = reading_ch0;
  assign reading[1] = reading_ch1;
  assign reading[2] = reading_ch2;

  always_comb begin
    cond          = 20'h00000;
    cond[10:1]    = fault_flags;
    cond[11]      = storage_disconnected;
    cond[12]      = background_active;
    cond[13]      = span_active;
    cond[14]      = zero_active;
    cond[15]      = system_fault | (|fault_flags);
    cond[16]      = maint;
    cond[19:17]   = over;
  end

  // ************************************************************
  // Analog channels
  // ************************************************************
  genvar c;
  generate
    for (c = 0; c < alarm_pkg::NUM_ANALOG; c++) begin : g_chan
      logic [31:0] range_new;
      assign range_new = merge({16'h0000, std_range[c]}, w_data_q, wmask);

      always_ff @(posedge aclk) begin
        if (!aresetn) begin
          std_range[c] <= alarm_pkg::RANGE_RST;
        end else if (ce && do_write
                     && wr_idx == alarm_pkg::RANGE_OFS[7:2] + 6'(c)) begin
          std_range[c] <= range_new[15:0];
        end
      end

      overrange_tracker u_ovr (
        .aclk      (aclk),
        .aresetn   (aresetn),
        .ce        (ce),
        .enable    (ovr_en[c]),
        .reading   (reading[c]),
        .std_range (std_range[c]),
        .over      (over[c])
      );
    end
  endgenerate

  // ************************************************************
  // Alarm outputs
  // ************************************************************
  genvar i;
  generate
    for (i = 0; i < alarm_pkg::NUM_OUT; i++) begin : g_out
      logic [31:0] cfg_new;
      assign cfg_new = merge({23'h000000, cfg_pol[i], 3'h0, cfg_sel[i]},
                             w_data_q, wmask);

      always_ff @(posedge aclk) begin
        if (!aresetn) begin
          cfg_sel[i] <= alarm_pkg::CFG_SEL_RST;
          cfg_pol[i] <= alarm_pkg::CFG_POL_RST;
        end else if (ce && do_write
                     && wr_idx == alarm_pkg::CFG_OFS[7:2] + 6'(i)) begin
          cfg_sel[i] <= cfg_new[4:0];
          cfg_pol[i] <= cfg_new[alarm_pkg::CFG_POL_BIT];
        end
      end

      alarm_pin_driver u_pin (
        .aclk        (aclk),
        .aresetn     (aresetn),
        .ce          (ce),
        .cond        (cond),
        .sel         (cfg_sel[i]),
        .active_high (cfg_pol[i]),
        .asserted    (asserted[i]),
        .pin         (alarm_pin[i])
      );
    end
  endgenerate

  // ************************************************************
  // Events and interrupt
  // ************************************************************
  logic       rd_take;
  logic [7:0] status_clr;
  logic [7:0] status_set;

  assign rd_take    = ce & arvalid & arready;
  assign status_clr = (rd_take && araddr[7:2] == alarm_pkg::STATUS_OFS[7:2]) ? 8'hFF : 8'h00;
  assign status_set = asserted & ~asserted_d;

  // A new event in the read-clear cycle survives the clear
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      asserted_d <= 8'h00;
      status     <= 8'h00;
    end else if (ce) begin
      asserted_d <= asserted;
      status     <= (status & ~status_clr) | status_set;
    end
  end

  assign irq = |(status & mask);

  // ************************************************************
  // Read channel
  // ************************************************************
  logic [31:0] rd_word;
  logic        rd_hit;
  logic [5:0]  rd_idx;

  assign arready = ce & ~rvalid;
  assign rd_idx  = araddr[7:2];
  assign rd_hit  = addr_ok(rd_idx);

  always_comb begin
    rd_word = 32'h00000000;
    if (rd_idx < alarm_pkg::STATUS_OFS[7:2]) begin
      rd_word = {23'h000000, cfg_pol[rd_idx[2:0]], 3'h0, cfg_sel[rd_idx[2:0]]};
    end else if (rd_idx == alarm_pkg::STATUS_OFS[7:2]) begin
      rd_word = {24'h000000, status};
    end else if (rd_idx == alarm_pkg::MASK_OFS[7:2]) begin
      rd_word = {24'h000000, mask};
    end else if (rd_idx == alarm_pkg::LEVEL_OFS[7:2]) begin
      rd_word = {21'h000000, over, asserted};
    end else if (rd_idx == alarm_pkg::CTRL_OFS[7:2]) begin
      rd_word = {28'h0000000, ovr_en, maint};
    end else if (rd_hit) begin
      rd_word = {16'h0000, std_range[2'(rd_idx - alarm_pkg::RANGE_OFS[7:2])]};
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid <= 1'b0;
      rdata  <= 32'h00000000;
      rresp  <= alarm_pkg::RESP_OKAY;
    end else if (ce) begin
      if (rd_take) begin
        rvalid <= 1'b1;
        rdata  <= rd_word;
        rresp  <= rd_hit ? alarm_pkg::RESP_OKAY : alarm_pkg::RESP_SLVERR;
      end else if (rvalid && rready) begin
        rvalid <= 1'b0;
      end
    end
  end

  // ************************************************************
  // Checks
  // ************************************************************
  property p_sysfault;
    @(posedge aclk) disable iff (!aresetn)
    (ce && cfg_sel[6] == alarm_pkg::system_fault_source && cfg_pol[6]
      && (system_fault || (|fault_flags))) |=> alarm_pin[6];
  endproperty
  a_sysfault: assert property (p_sysfault) else $error("system fault misses a fault");

  property p_maint;
    @(posedge aclk) disable iff (!aresetn)
    (ce && do_write && wr_idx == alarm_pkg::CTRL_OFS[7:2] && w_strb_q[0])
      |=> (cond[16] == $past(w_data_q[alarm_pkg::CTRL_MAINT]));
  endproperty
  a_maint: assert property (p_maint) else $error("maintenance source stale");

  property p_cfg_write;
    @(posedge aclk) disable iff (!aresetn)
    (ce && do_write && wr_idx == alarm_pkg::CFG_OFS[7:2] && w_strb_q[0])
      |=> (cfg_sel[0] == $past(w_data_q[4:0]));
  endproperty
  a_cfg_write: assert property (p_cfg_write) else $error("source select not stored");

  property p_pin_one_cycle;
    @(posedge aclk) disable iff (!aresetn)
    (ce && cfg_sel[0] == alarm_pkg::maintenance_source && cfg_pol[0])
      |=> (alarm_pin[0] == $past(maint));
  endproperty
  a_pin_one_cycle: assert property (p_pin_one_cycle) else $error("pin not one cycle late");

  property p_low_active;
    @(posedge aclk) disable iff (!aresetn)
    (ce && cfg_sel[1] == alarm_pkg::system_fault_source && !cfg_pol[1] && cond[15])
      |=> !alarm_pin[1];
  endproperty
  a_low_active: assert property (p_low_active) else $error("active-low pin not low");

  property p_ovr_source;
    @(posedge aclk) disable iff (!aresetn)
    (ce && cfg_sel[2] == alarm_pkg::analog_ch0_overrange_source && cfg_pol[2])
      |=> (alarm_pin[2] == $past(over[0]));
  endproperty
  a_ovr_source: assert property (p_ovr_source) else $error("over-range pin wrong");

  property p_event_sticky;
    @(posedge aclk) disable iff (!aresetn)
    (ce && status_set[0]) |=> status[0];
  endproperty
  a_event_sticky: assert property (p_event_sticky) else $error("event lost");

  property p_write_resp;
    @(posedge aclk) disable iff (!aresetn)
    (ce && do_write) |=> (bvalid && bresp == ($past(wr_hit) ? 2'h0 : 2'h2));
  endproperty
  a_write_resp: assert property (p_write_resp) else $error("write response missing");

endmodule // status_alarm_output_mapper

/* File: testbench/alarm_logger_model.sv */
// Alarm logger model standing on the far side of the eight alarm pins
`timescale 1ns/1ps
module alarm_logger_model (
  // Clock
  input  wire logic       aclk,
  // Pins in, logged state out
  input  wire logic [7:0] alarm_pin,
  output logic      [7:0] seen
);
  // Pins are push-pull, so the logger needs no pull level; it samples once a cycle
  always_ff @(posedge aclk) begin
    seen <= alarm_pin;
  end
endmodule // alarm_logger_model

/* File: testbench/status_alarm_output_mapper_tb.sv */
// Self-checking bench for the alarm output mapper
`timescale 1ns/1ps
module status_alarm_output_mapper_tb;
  // ************************************************************
  // Signals
  // ************************************************************
  logic        aclk = 0, aresetn = 0, ce = 1;
  logic [7:0]  awaddr = 0, araddr = 0, alarm_pin, seen;
  logic [2:0]  awprot = 0, arprot = 0;
  logic        awvalid = 0, wvalid = 0, bready = 1, arvalid = 0, rready = 1;
  logic        awready, wready, bvalid, arready, rvalid, irq;
  logic [31:0] wdata = 0, rdata, d;
  logic [3:0]  wstrb = 4'hF;
  logic [1:0]  bresp, rresp, r;
  logic [9:0]  fault_flags = 0;
  logic        storage_disconnected = 0, background_active = 0, span_active = 0;
  logic        zero_active = 0, system_fault = 0;
  logic [15:0] reading_ch0 = 0, reading_ch1 = 0, reading_ch2 = 0;
  int          mismatches = 0, checks = 0;

  status_alarm_output_mapper u_dut (.aclk, .aresetn, .ce, .awaddr, .awprot, .awvalid,
    .awready, .wdata, .wstrb, .wvalid, .wready, .bresp, .bvalid, .bready, .araddr,
    .arprot, .arvalid, .arready, .rdata, .rresp, .rvalid, .rready, .fault_flags,
    .storage_disconnected, .background_active, .span_active, .zero_active,
    .system_fault, .reading_ch0, .reading_ch1, .reading_ch2, .alarm_pin, .irq);
  alarm_logger_model u_log (.aclk(aclk), .alarm_pin(alarm_pin), .seen(seen));

  initial forever #2.5 aclk = ~aclk;

  // ************************************************************
  // Bus and check tasks
  // ************************************************************
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    checks++;
    if (s !== e) begin
      mismatches++;
      $display("Error at %0t ns: seen %h expected %h", $time, s, e);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] v, output logic [1:0] rs);
    logic ad, dd;
    ad = 0;
    dd = 0;
    awaddr <= a;
    wdata <= v;
    awvalid <= 1;
    wvalid <= 1;
    do begin
      @(posedge aclk);
      if (awready === 1'b1) ad = 1;
      if (wready === 1'b1) dd = 1;
      if (ad) awvalid <= 0;
      if (dd) wvalid <= 0;
    end while (!(ad && dd));
    do @(posedge aclk); while (bvalid !== 1'b1);
    rs = bresp;
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] v, output logic [1:0] rs);
    araddr <= a;
    arvalid <= 1;
    do @(posedge aclk); while (arready !== 1'b1);
    arvalid <= 0;
    do @(posedge aclk); while (rvalid !== 1'b1);
    v = rdata;
    rs = rresp;
  endtask
  function automatic logic [31:0] cf(input logic pol, input int s);
    return {23'h0, pol, 3'h0, 5'(s)};
  endfunction
  function automatic logic [7:0] ca(input int i);
    return alarm_pkg::CFG_OFS + 8'(4 * i);
  endfunction
  // Checks read at the edge see the values settled in the cycle before it
  task automatic st;
    repeat (3) @(posedge aclk);
  endtask

  // ************************************************************
  // Scenarios
  // ************************************************************
  task automatic t_reset;
    chk(alarm_pin, 8'h00);
    chk(seen, 8'h00);
    for (int i = 0; i < 8; i++) begin
      rd(ca(i), d, r);
      chk(d, 32'h00000100);
    end
    rd(alarm_pkg::RANGE_OFS, d, r);
    chk(d, 32'h00001000);
  endtask
  task automatic t_faults;
    for (int k = 1; k <= 10; k++) begin
      wr(ca(k % 8), cf(1, k), r);
      fault_flags <= 10'(1) << (k - 1);
      st;
      chk(alarm_pin, 8'h01 << (k % 8));
      fault_flags <= 0;
      st;
      chk(alarm_pin, 8'h00);
    end
  endtask
  task automatic t_low;
    for (int k = 0; k < 4; k++) begin
      wr(ca(3), cf(0, 11 + k), r);
      {storage_disconnected, background_active, span_active, zero_active} <= 4'h8 >> k;
      st;
      chk(alarm_pin[3], 1'b0);
      {storage_disconnected, background_active, span_active, zero_active} <= 4'h0;
      st;
      chk(alarm_pin[3], 1'b1);
    end
  endtask
  task automatic t_disabled;
    wr(ca(4), cf(0, 0), r);
    wr(ca(5), cf(1, 0), r);
    wr(alarm_pkg::CTRL_OFS, 32'h0000000F, r);
    fault_flags <= 10'h3FF;
    system_fault <= 1;
    st;
    chk(alarm_pin[5:4], 2'b01);
    fault_flags <= 0;
    system_fault <= 0;
    wr(alarm_pkg::CTRL_OFS, 32'h0, r);
  endtask
  task automatic t_sys_maint;
    wr(ca(6), cf(1, 15), r);
    system_fault <= 1;
    st;
    chk(alarm_pin[6], 1'b1);
    system_fault <= 0;
    fault_flags <= 10'h200;
    st;
    chk(alarm_pin[6], 1'b1);
    fault_flags <= 0;
    st;
    chk(alarm_pin[6], 1'b0);
    wr(ca(7), cf(1, 16), r);
    wr(alarm_pkg::CTRL_OFS, 32'h1, r);
    st;
    chk(alarm_pin[7], 1'b1);
    wr(alarm_pkg::CTRL_OFS, 32'h0, r);
    st;
    chk(alarm_pin[7], 1'b0);
  endtask
  task automatic t_overrange;
    logic [15:0] v [4] = '{16'h0383, 16'h0384, 16'h0321, 16'h0320};
    logic        e [4] = '{1'b0, 1'b1, 1'b1, 1'b0};
    for (int c = 0; c < 3; c++) begin
      wr(ca(c), cf(1, 17 + c), r);
      wr(alarm_pkg::RANGE_OFS + 8'(4 * c), 32'h000003E8, r);
      wr(alarm_pkg::CTRL_OFS, 32'h2 << c, r);
      for (int j = 0; j < 4; j++) begin
        if (c == 0) reading_ch0 <= v[j];
        if (c == 1) reading_ch1 <= v[j];
        if (c == 2) reading_ch2 <= v[j];
        st;
        chk(alarm_pin[2:0], 3'(e[j]) << c);
      end
    end
    wr(alarm_pkg::CTRL_OFS, 32'h0, r);
  endtask
  task automatic t_timing;
    wr(ca(1), cf(1, 1), r);
    @(posedge aclk);
    fault_flags <= 10'h001;
    @(posedge aclk);
    chk(alarm_pin[1], 1'b0);
    @(posedge aclk);
    chk(alarm_pin[1], 1'b1);
    // A frozen clock enable must also hold the pin, not let it follow the fault
    @(posedge aclk);
    ce <= 0;
    fault_flags <= 0;
    st;
    chk(alarm_pin[1], 1'b1);
    ce <= 1;
    st;
    chk(alarm_pin[1], 1'b0);
  endtask
  task automatic t_irq;
    wr(alarm_pkg::MASK_OFS, 32'h0, r);
    rd(alarm_pkg::STATUS_OFS, d, r);
    fault_flags <= 10'h001;
    st;
    chk(irq, 1'b0);
    wr(alarm_pkg::MASK_OFS, 32'h2, r);
    chk(irq, 1'b1);
    rd(alarm_pkg::STATUS_OFS, d, r);
    chk(d & 32'h2, 32'h2);
    st;
    chk(irq, 1'b0);
    fault_flags <= 0;
    rd(8'hF0, d, r);
    chk(d, 32'h0);
    chk(r, alarm_pkg::RESP_SLVERR);
    wr(8'hF0, 32'h1, r);
    chk(r, alarm_pkg::RESP_SLVERR);
  endtask

  task automatic end_of_test;
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  // The full sequence needs a few hundred cycles; 100 us leaves a wide margin
  initial begin
    #100us;
    mismatches++;
    end_of_test;
  end

  initial begin
    repeat (10) @(posedge aclk);
    aresetn <= 1;
    @(posedge aclk);
    t_reset;
    t_faults;
    t_low;
    t_disabled;
    t_sys_maint;
    t_overrange;
    t_timing;
    t_irq;
    end_of_test;
  end
endmodule // status_alarm_output_mapper_tb
